// File: srm_regs.sv
// per-thread monitoring tag association and event select/counter registers
//
// Functional notes
// - tag internal operations with association tag
// - tag width is ceil log2 of max plus one
// - association register reads zero after power-on
// - tag field at most ten bits, binary
// - tag above maximum faults the write
// - reserved bit change faults the write
// - tag meaning is package wide
// - highest tags may lack bandwidth support
// - no interrupt, no threshold, sampled only
// - separate from general performance counters
// - event code 7:0, tag 41:32
// - codes 01H, 02H, 03H; others reserved
// - bad tag or code sets bit 63
// - missing data sets bit 62; here only while bit 63 is clear
// - count in 61:0, valid when flags clear
// - registers accessible at any time
// - power saving may shift reported counts
// - interrupt delivery leaves state untouched
`default_nettype none
`timescale 1ns/1ps

module srm_regs
(
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // msr access port
  input  wire logic                           msr_req,
  input  wire logic                           msr_wr,
  input  wire logic [1:0]                     msr_sel,
  input  wire logic [63:0]                    msr_wdata,
  output logic                                msr_ack,
  output logic                                msr_fault,
  output logic      [63:0]                    msr_rdata,
  // internal operation tagging
  input  wire logic                           op_valid,
  output logic                                op_tag_valid,
  output logic      [srm_pkg::TAG_W-1:0]      op_tag,
  // monitoring data lookup, keyed by tag and event only
  output logic      [srm_pkg::TAG_W-1:0]      lookup_tag,
  output logic      [srm_pkg::EVT_CODE_W-1:0] lookup_event,
  input  wire logic                           lookup_avail,
  input  wire logic [srm_pkg::CTR_DATA_W-1:0] lookup_data
);

  srm_pkg::srm_state_t st;
  srm_pkg::srm_state_t next_st;

  logic [63:0]                     ctr_word;
  logic [srm_pkg::TAG_FIELD_W-1:0] wr_tag;
  logic                            is_write;
  logic                            is_read;

  // tag field of a write word, full documented span
  function automatic logic [srm_pkg::TAG_FIELD_W-1:0] tag_field
  (
    input logic [63:0] w,
    input int          lsb
  );
    tag_field = w[lsb +: srm_pkg::TAG_FIELD_W];
  endfunction : tag_field

  // reserved bits read as zero, so any set bit outside the mask is a change
  function automatic logic rsvd_set
  (
    input logic [63:0] w,
    input logic [63:0] mask
  );
    rsvd_set = (w & ~mask) != 64'h0000_0000_0000_0000;
  endfunction : rsvd_set

  // counter word follows the selection held right now, not a snapshot
  srm_readout srm_readout_i
  (
    .evt_code   (st.evt_code),
    .evt_tag    (st.evt_tag),
    .data_avail (lookup_avail),
    .data       (lookup_data),
    .word       (ctr_word)
  );

  assign is_write = msr_req && msr_wr;
  assign is_read  = msr_req && !msr_wr;

  always_comb
  begin
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.fault = 1'b0;
    wr_tag        = '0;
    // each operation carries the tag active at issue
    next_st.op_tag_valid = op_valid;
    if (op_valid)
    begin
      next_st.op_tag = st.assoc_tag;
    end
    // accepted in every cycle, no busy state
    if (msr_req)
    begin
      next_st.ack   = 1'b1;
      next_st.rdata = 64'h0000_0000_0000_0000;
      unique case (msr_sel)
        srm_pkg::SEL_ASSOC:
        begin
          wr_tag = tag_field(msr_wdata, srm_pkg::ASSOC_TAG_LSB);
          if (!msr_wr)
          begin
            next_st.rdata = 64'(st.assoc_tag);
          end
          else if (rsvd_set(msr_wdata, srm_pkg::ASSOC_WMASK))
          begin
            next_st.fault = 1'b1;
          end
          else if (wr_tag > srm_pkg::MAX_TAG_ALL)
          begin
            next_st.fault = 1'b1;
          end
          else
          begin
            next_st.assoc_tag = wr_tag[srm_pkg::TAG_W-1:0];
          end
        end
        srm_pkg::SEL_EVTSEL:
        begin
          wr_tag = tag_field(msr_wdata, srm_pkg::EVT_TAG_LSB);
          if (!msr_wr)
          begin
            next_st.rdata = (64'(st.evt_tag) << srm_pkg::EVT_TAG_LSB)
                          | 64'(st.evt_code);
          end
          else if (rsvd_set(msr_wdata, srm_pkg::EVTSEL_WMASK))
          begin
            next_st.fault = 1'b1;
          end
          else if (wr_tag > srm_pkg::MAX_TAG_ALL)
          begin
            next_st.fault = 1'b1;
          end
          else
          begin
            // reserved codes are stored and reported through the error flag
            next_st.evt_tag  = wr_tag[srm_pkg::TAG_W-1:0];
            next_st.evt_code =
              msr_wdata[srm_pkg::EVT_CODE_LSB +: srm_pkg::EVT_CODE_W];
          end
        end
        srm_pkg::SEL_CTR:
        begin
          if (!msr_wr)
          begin
            next_st.rdata = ctr_word;
          end
          else
          begin
            next_st.fault = 1'b1;
          end
        end
        default:
        begin
          next_st.fault = 1'b1;
        end
      endcase
    end
  end

  // no interrupt delivery input exists: nothing outside software writes
  // can alter the tag or the selection
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st              <= '0;
      st.assoc_tag    <= srm_pkg::ASSOC_TAG_RST;
      st.evt_tag      <= srm_pkg::EVT_TAG_RST;
      st.evt_code     <= srm_pkg::EVT_CODE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // counts come only by sampling; this block owns no threshold or irq
  assign msr_ack      = st.ack;
  assign msr_fault    = st.fault;
  assign msr_rdata    = st.rdata;
  assign op_tag_valid = st.op_tag_valid;
  assign op_tag       = st.op_tag;
  // lookup shares no state with performance counters; one tag space for
  // every processor of the package, so no processor id goes out
  assign lookup_tag   = st.evt_tag;
  assign lookup_event = st.evt_code;
  // occupancy may drop and bandwidth rise under power saving; the
  // lookup source reports that directly, nothing here filters it

  property p_assoc_read;
    @(posedge core_clk) disable iff (rst)
    is_read && msr_sel == srm_pkg::SEL_ASSOC
      |=> msr_rdata == 64'($past(st.assoc_tag));
  endproperty
  a_assoc_read: assert property (p_assoc_read)
    else $error("association read not tag field only");

  property p_reset_zero;
    @(posedge core_clk)
    $past(rst) && !rst |-> st.assoc_tag == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("association tag not zero after reset");

  property p_ack_next;
    @(posedge core_clk) disable iff (rst)
    msr_req |=> msr_ack ##1 !msr_ack || $past(msr_req);
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("request not answered in one cycle");

  property p_big_tag_fault;
    @(posedge core_clk) disable iff (rst)
    is_write && msr_sel == srm_pkg::SEL_ASSOC
      && tag_field(msr_wdata, srm_pkg::ASSOC_TAG_LSB) > srm_pkg::MAX_TAG_ALL
      |=> msr_fault && $stable(st.assoc_tag);
  endproperty
  a_big_tag_fault: assert property (p_big_tag_fault)
    else $error("oversized tag write not faulted");

  property p_rsvd_fault;
    @(posedge core_clk) disable iff (rst)
    is_write && msr_sel == srm_pkg::SEL_EVTSEL
      && rsvd_set(msr_wdata, srm_pkg::EVTSEL_WMASK)
      |=> msr_fault && $stable(st.evt_tag) && $stable(st.evt_code);
  endproperty
  a_rsvd_fault: assert property (p_rsvd_fault)
    else $error("reserved bit write not faulted");

  property p_good_write;
    @(posedge core_clk) disable iff (rst)
    is_write && msr_sel == srm_pkg::SEL_ASSOC
      && !rsvd_set(msr_wdata, srm_pkg::ASSOC_WMASK)
      && tag_field(msr_wdata, srm_pkg::ASSOC_TAG_LSB) <= srm_pkg::MAX_TAG_ALL
      |=> !msr_fault
      && 64'(st.assoc_tag) == $past(msr_wdata);
  endproperty
  a_good_write: assert property (p_good_write)
    else $error("legal association write lost");

  property p_op_tag;
    @(posedge core_clk) disable iff (rst)
    op_valid |=> op_tag_valid && op_tag == $past(st.assoc_tag);
  endproperty
  a_op_tag: assert property (p_op_tag)
    else $error("operation tagged with wrong tag");

  property p_err_code;
    @(posedge core_clk) disable iff (rst)
    is_read && msr_sel == srm_pkg::SEL_CTR
      && (st.evt_code == 8'h00 || st.evt_code > srm_pkg::EVT_LOCAL_BW)
      |=> msr_rdata[srm_pkg::CTR_ERR_BIT]
      && msr_rdata[srm_pkg::CTR_DATA_W-1:0] == '0;
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("reserved event code not flagged");

  property p_bw_tag;
    @(posedge core_clk) disable iff (rst)
    is_read && msr_sel == srm_pkg::SEL_CTR
      && st.evt_code == srm_pkg::EVT_TOTAL_BW
      && srm_pkg::TAG_FIELD_W'(st.evt_tag) > srm_pkg::MAX_TAG_BW
      |=> msr_rdata[srm_pkg::CTR_ERR_BIT];
  endproperty
  a_bw_tag: assert property (p_bw_tag)
    else $error("bandwidth tag beyond range not flagged");

  property p_unavail;
    @(posedge core_clk) disable iff (rst)
    is_read && msr_sel == srm_pkg::SEL_CTR
      && st.evt_code == srm_pkg::EVT_OCC && !lookup_avail
      |=> msr_rdata[srm_pkg::CTR_UNAV_BIT]
      && !msr_rdata[srm_pkg::CTR_ERR_BIT];
  endproperty
  a_unavail: assert property (p_unavail)
    else $error("unavailable data not flagged");

  property p_valid_data;
    @(posedge core_clk) disable iff (rst)
    is_read && msr_sel == srm_pkg::SEL_CTR
      && st.evt_code == srm_pkg::EVT_OCC && lookup_avail
      |=> msr_rdata == 64'($past(lookup_data));
  endproperty
  a_valid_data: assert property (p_valid_data)
    else $error("valid count not returned");

  property p_ctr_wr_fault;
    @(posedge core_clk) disable iff (rst)
    is_write && msr_sel == srm_pkg::SEL_CTR |=> msr_fault;
  endproperty
  a_ctr_wr_fault: assert property (p_ctr_wr_fault)
    else $error("counter write not faulted");

  property p_no_spont;
    @(posedge core_clk) disable iff (rst)
    !msr_req |=> $stable(st.assoc_tag) && $stable(st.evt_tag)
      && !msr_ack;
  endproperty
  a_no_spont: assert property (p_no_spont)
    else $error("state changed without a write");

  property p_lookup;
    @(posedge core_clk) disable iff (rst)
    is_write && msr_sel == srm_pkg::SEL_EVTSEL
      && !rsvd_set(msr_wdata, srm_pkg::EVTSEL_WMASK)
      && tag_field(msr_wdata, srm_pkg::EVT_TAG_LSB) <= srm_pkg::MAX_TAG_ALL
      |=> lookup_event == $past(msr_wdata[7:0])
      && 10'(lookup_tag) == $past(msr_wdata[41:32]);
  endproperty
  a_lookup: assert property (p_lookup)
    else $error("selection not driven to lookup");

  property p_evt_read;
    @(posedge core_clk) disable iff (rst)
    is_read && msr_sel == srm_pkg::SEL_EVTSEL
      |=> msr_rdata[srm_pkg::EVT_TAG_LSB +: srm_pkg::TAG_FIELD_W]
          == 10'($past(st.evt_tag))
      && msr_rdata[srm_pkg::EVT_CODE_W-1:0] == $past(st.evt_code)
      && !msr_fault;
  endproperty
  a_evt_read: assert property (p_evt_read)
    else $error("event select readback wrong");

  property p_unmapped;
    @(posedge core_clk) disable iff (rst)
    msr_req && msr_sel == 2'h3
      |=> msr_fault && msr_rdata == 64'h0000_0000_0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped select not faulted");

  property p_op_idle;
    @(posedge core_clk) disable iff (rst)
    !op_valid |=> !op_tag_valid && $stable(op_tag);
  endproperty
  a_op_idle: assert property (p_op_idle)
    else $error("tag issued without an operation");

endmodule : srm_regs

`default_nettype wire

// File: srm_pkg.sv
// constants and state type for the shared resource monitor registers
`default_nettype none

package srm_pkg;

  // register select codes on the msr access port
  localparam logic [1:0] SEL_ASSOC  = 2'h0;
  localparam logic [1:0] SEL_EVTSEL = 2'h1;
  localparam logic [1:0] SEL_CTR    = 2'h2;

  // highest tag values per resource type
  localparam logic [9:0] MAX_TAG_ALL = 10'h03F;
  localparam logic [9:0] MAX_TAG_OCC = 10'h03F;
  localparam logic [9:0] MAX_TAG_BW  = 10'h01F;

  // field layout
  localparam int TAG_FIELD_W   = 10;
  localparam int TAG_W         = $clog2(int'(MAX_TAG_ALL) + 1);
  localparam int ASSOC_TAG_LSB = 0;
  localparam int EVT_TAG_LSB   = 32;
  localparam int EVT_CODE_LSB  = 0;
  localparam int EVT_CODE_W    = 8;
  localparam int CTR_ERR_BIT   = 63;
  localparam int CTR_UNAV_BIT  = 62;
  localparam int CTR_DATA_W    = 62;

  // writable bits; everything else is reserved and must stay zero
  localparam logic [63:0] ASSOC_WMASK  = 64'h0000_0000_0000_03FF;
  localparam logic [63:0] EVTSEL_WMASK = 64'h0000_03FF_0000_00FF;

  // event codes
  localparam logic [7:0] EVT_OCC      = 8'h01;
  localparam logic [7:0] EVT_TOTAL_BW = 8'h02;
  localparam logic [7:0] EVT_LOCAL_BW = 8'h03;

  // reset values
  localparam logic [TAG_W-1:0]      ASSOC_TAG_RST = '0;
  localparam logic [TAG_W-1:0]      EVT_TAG_RST   = '0;
  localparam logic [EVT_CODE_W-1:0] EVT_CODE_RST  = 8'h00;

  typedef struct packed {
    logic [TAG_W-1:0]      assoc_tag;
    logic [TAG_W-1:0]      evt_tag;
    logic [EVT_CODE_W-1:0] evt_code;
    logic                  ack;
    logic                  fault;
    logic [63:0]           rdata;
    logic                  op_tag_valid;
    logic [TAG_W-1:0]      op_tag;
  } srm_state_t;

endpackage : srm_pkg

`default_nettype wire

// File: srm_readout.sv
// counter readout word builder: error, unavailable and data fields
`default_nettype none
`timescale 1ns/1ps

module srm_readout
(
  // current selection
  input  wire logic [srm_pkg::EVT_CODE_W-1:0] evt_code,
  input  wire logic [srm_pkg::TAG_W-1:0]      evt_tag,
  // monitored data for the selection
  input  wire logic                           data_avail,
  input  wire logic [srm_pkg::CTR_DATA_W-1:0] data,
  // assembled counter word
  output logic      [63:0]                    word
);

  logic                         code_ok;
  logic [srm_pkg::TAG_FIELD_W-1:0] tag_max;
  logic                         err;
  logic                         unav;

  always_comb
  begin
    code_ok = (evt_code == srm_pkg::EVT_OCC)
           || (evt_code == srm_pkg::EVT_TOTAL_BW)
           || (evt_code == srm_pkg::EVT_LOCAL_BW);
    // upper tags may exist for occupancy only
    tag_max = (evt_code == srm_pkg::EVT_OCC) ? srm_pkg::MAX_TAG_OCC
                                             : srm_pkg::MAX_TAG_BW;
    err  = !code_ok
        || (srm_pkg::TAG_FIELD_W'(evt_tag) > tag_max);
    unav = !err && !data_avail;
    word = '0;
    word[srm_pkg::CTR_ERR_BIT]  = err;
    word[srm_pkg::CTR_UNAV_BIT] = unav;
    // data zeroed whenever a flag is up so it is never mistaken as valid
    if (!err && !unav)
    begin
      word[srm_pkg::CTR_DATA_W-1:0] = data;
    end
  end

endmodule : srm_readout

`default_nettype wire

// File: srm_regs_tb.sv
// self-checking bench for the tag association and event select registers
`default_nettype none
`timescale 1ns/1ps

module srm_regs_tb;
  logic                           core_clk;
  logic                           rst;
  logic                           msr_req;
  logic                           msr_wr;
  logic [1:0]                     msr_sel;
  logic [63:0]                    msr_wdata;
  logic                           msr_ack;
  logic                           msr_fault;
  logic [63:0]                    msr_rdata;
  logic                           op_valid;
  logic                           op_tag_valid;
  logic [srm_pkg::TAG_W-1:0]      op_tag;
  logic [srm_pkg::TAG_W-1:0]      lookup_tag;
  logic [srm_pkg::EVT_CODE_W-1:0] lookup_event;
  logic                           lookup_avail;
  logic [srm_pkg::CTR_DATA_W-1:0] lookup_data;
  int                             err_count;
  int                             check_count;
  int                             seed;
  logic [64:0]                    acc_q[$];
  logic [srm_pkg::TAG_W-1:0]      tag_q[$];
  logic [13:0]                    lkp_q[$];
  logic [64:0]                    exp_acc;
  logic [13:0]                    exp_lkp;
  logic [5:0]                     exp_tag;
  logic [9:0]                     saved_tag;
  logic [9:0]                     m_assoc;
  logic [9:0]                     m_etag;
  logic [7:0]                     m_code;
  logic [63:0] aw [6] = '{64'h3F, 64'h40, 64'h3FF, 64'h400,
                          64'h8000_0000_0000_0005, 64'h5};
  logic [63:0] ew [3] = '{64'h100, 64'h0000_0400_0000_0000,
                          64'h0000_0040_0000_0001};
  logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hFF};
  logic [9:0]  tags [4]  = '{10'h000, 10'h01F, 10'h020, 10'h03F};

  srm_regs srm_regs_i (
    .core_clk     (core_clk),
    .rst          (rst),
    .msr_req      (msr_req),
    .msr_wr       (msr_wr),
    .msr_sel      (msr_sel),
    .msr_wdata    (msr_wdata),
    .msr_ack      (msr_ack),
    .msr_fault    (msr_fault),
    .msr_rdata    (msr_rdata),
    .op_valid     (op_valid),
    .op_tag_valid (op_tag_valid),
    .op_tag       (op_tag),
    .lookup_tag   (lookup_tag),
    .lookup_event (lookup_event),
    .lookup_avail (lookup_avail),
    .lookup_data  (lookup_data)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic cmp_acc(input logic [64:0] got, input logic [64:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_acc

  task automatic cmp_tag(input logic [5:0] got, input logic [5:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_tag

  task automatic cmp_lkp(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_lkp

  function automatic logic [63:0] ctr_word(input logic av,
                                           input logic [61:0] d);
    logic err;
    err = !(m_code inside {8'h01, 8'h02, 8'h03}) ||
          m_etag > ((m_code == 8'h01) ? srm_pkg::MAX_TAG_OCC
                                      : srm_pkg::MAX_TAG_BW);
    if (err)
      return {2'h2, 62'h0};
    if (!av)
      return {2'h1, 62'h0};
    return {2'h0, d};
  endfunction : ctr_word

  // one access per call; back-to-back calls keep the request high
  task automatic acc(input logic wr, input logic [1:0] sel,
                     input logic [63:0] wd);
    logic        f;
    logic [63:0] rd;
    logic        av;
    logic [61:0] ld;
    av = 1'($random(seed));
    ld = 62'({$random(seed), $random(seed)});
    f = 1'b0;
    rd = 64'h0;
    if (wr)
    begin
      if (sel == 2'h0)
        f = |(wd & ~srm_pkg::ASSOC_WMASK) || wd[9:0] > srm_pkg::MAX_TAG_ALL;
      else if (sel == 2'h1)
        f = |(wd & ~srm_pkg::EVTSEL_WMASK) ||
            wd[41:32] > srm_pkg::MAX_TAG_ALL;
      else
        f = 1'b1;
      if (!f && sel == 2'h0)
        m_assoc = wd[9:0];
      if (!f && sel == 2'h1)
        {m_etag, m_code} = {wd[41:32], wd[7:0]};
    end
    else if (sel == 2'h0)
      rd = {54'h0, m_assoc};
    else if (sel == 2'h1)
      rd = {22'h0, m_etag, 24'h0, m_code};
    else if (sel == 2'h2)
      rd = ctr_word(av, ld);
    else
      f = 1'b1;
    @(posedge core_clk);
    msr_req <= 1'b1;
    msr_wr <= wr;
    msr_sel <= sel;
    msr_wdata <= wd;
    lookup_avail <= av;
    lookup_data <= ld;
    acc_q.push_back({f, rd});
    lkp_q.push_back({m_etag[5:0], m_code});
  endtask : acc

  task automatic idle;
    @(posedge core_clk);
    msr_req <= 1'b0;
  endtask : idle

  task automatic ops(input int n);
    logic v;
    repeat (n)
    begin
      v = 1'($random(seed));
      @(posedge core_clk);
      op_valid <= v;
      if (v)
        tag_q.push_back(m_assoc[5:0]);
    end
    @(posedge core_clk);
    op_valid <= 1'b0;
  endtask : ops

  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // sample after the edge's updates have landed
  always @(posedge core_clk)
  begin
    #1;
    if (msr_ack === 1'b1)
    begin
      exp_acc = acc_q.size() ? acc_q.pop_front() : 'x;
      exp_lkp = lkp_q.size() ? lkp_q.pop_front() : 'x;
      cmp_acc({msr_fault, msr_rdata}, exp_acc);
      cmp_lkp({lookup_tag, lookup_event}, exp_lkp);
    end
    if (op_tag_valid === 1'b1)
    begin
      exp_tag = tag_q.size() ? tag_q.pop_front() : 'x;
      cmp_tag(op_tag, exp_tag);
    end
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    results();
  end

  initial
  begin
    seed = 23;
    err_count = 0;
    check_count = 0;
    rst = 1'b1;
    msr_req = 1'b0;
    msr_wr = 1'b0;
    msr_sel = 2'h0;
    msr_wdata = 64'h0;
    op_valid = 1'b0;
    lookup_avail = 1'b0;
    lookup_data = 62'h0;
    m_assoc = 10'h000;
    m_etag = 10'h000;
    m_code = 8'h00;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    acc(1'b0, 2'h0, 64'h0);
    acc(1'b0, 2'h1, 64'h0);
    acc(1'b0, 2'h2, 64'h0);
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, 2'h0, aw[i]);
      acc(1'b0, 2'h0, 64'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 2'h0, 64'($random(seed)) & 64'h3F);
      idle();
      ops(10);
    end
    // handler runs under its own tag, then puts the old one back
    saved_tag = m_assoc;
    acc(1'b1, 2'h0, 64'h3E);
    idle();
    ops(4);
    acc(1'b1, 2'h0, {54'h0, saved_tag});
    acc(1'b0, 2'h0, 64'h0);
    for (int i = 0; i < 6; i++)
      for (int j = 0; j < 4; j++)
      begin
        acc(1'b1, 2'h1, {22'h0, tags[j], 24'h0, codes[i]});
        acc(1'b0, 2'h2, 64'h0);
        acc(1'b0, 2'h2, 64'h0);
        acc(1'b0, 2'h1, 64'h0);
      end
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, 2'h1, ew[i]);
      acc(1'b0, 2'h1, 64'h0);
    end
    acc(1'b1, 2'h2, 64'h1);
    acc(1'b1, 2'h3, 64'h1);
    acc(1'b0, 2'h3, 64'h0);
    repeat (300)
    begin
      logic [31:0] r;
      r = $random(seed);
      acc(r[0], r[2:1] == 2'h3 ? 2'h2 : r[2:1],
          r[3] ? {$random(seed), $random(seed)}
               : {32'($random(seed)) & 32'h3F, 32'($random(seed))} &
                 (r[2:1] == 2'h1 ? srm_pkg::EVTSEL_WMASK : 64'h3F));
    end
    idle();
    repeat (3) @(posedge core_clk);
    // second reset in mid-run puts the selection back to zero
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    m_assoc = 10'h000;
    m_etag = 10'h000;
    m_code = 8'h00;
    acc(1'b0, 2'h0, 64'h0);
    acc(1'b0, 2'h2, 64'h0);
    idle();
    repeat (5) @(posedge core_clk);
    cmp_acc(65'(acc_q.size()), 65'h0);
    cmp_tag(6'(tag_q.size()), 6'h00);
    cmp_lkp(14'(lkp_q.size()), 14'h0000);
    results();
  end
endmodule : srm_regs_tb

`default_nettype wire
